// *** verilog/fps_fuse_program_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Keys burned as 256-bit images, others raw
// - Each fuse bit maps to one program bit
// - Word five holds pad fields and cipher
// - Key word k carries bits 32k+31..32k
// - Key 0x5A5A then command 0x2 burns
// - Burn done clears command, flags program
// - Key 0x5AA5 then command 0x1 reads
// - Read done clears command, flags read
// - Clear register bits clear pending flags
// - Interrupt line only for enabled events
// - Status shows enabled pending done events
// - Repeated separate burns are accepted
// - Burn only sets unlocked zero bits
// - Lock mask bit one locks, stays set
module fps_fuse_program_sequencer #(
   parameter int NUM_WORDS = fps_pkg::NUM_WORDS
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             fuse_irq,
   output logic      [19:0] flash_pad_route_select,
   output logic      [3:0]  flash_cipher_cfg
);

   logic [31:0]          prog_ff   [NUM_WORDS];
   logic [31:0]          fuse_ff   [NUM_WORDS];
   logic [31:0]          shadow_ff [NUM_WORDS];
   fps_pkg::fps_timing_t timing_ff;
   logic [7:0]           fuse_dac_cfg_reg_ff;
   logic [15:0]          fuse_op_key_ff;
   logic [1:0]           cmd_ff;
   logic [1:0]           raw_ff;
   logic [1:0]           fuse_irq_enable_ff;
   logic [1:0]           nxt_raw;
   logic [1:0]           fuse_irq_status;
   fps_pkg::fps_state_t  state_ff;
   logic [9:0]           count_ff;
   logic                 done_burn;
   logic                 done_read;
   logic [31:0]          prdata_ff;
   logic                 pready_ff;
   logic                 pslverr_ff;
   logic                 irq_ff;
   logic [19:0]          pad_ff;
   logic [3:0]           cipher_ff;
   logic                 setup;
   logic                 wr_en;
   logic                 start_burn;
   logic                 start_read;
   logic [31:0]          rd_word;
   logic                 rd_hit;

   // Word index of an offset inside a word array, or -1 when outside
   function automatic int word_index(input logic [11:0] addr,
                                     input logic [11:0] base);
      int idx;
      idx = -1;
      if (addr >= base && addr < base + 12'(4 * NUM_WORDS) &&
          addr[1:0] == 2'b00) begin
         idx = int'((addr - base) >> 2);
      end
      return idx;
   endfunction : word_index

   // Which write-lock bit guards a given fuse bit
   function automatic int lock_bit(input int w, input int b);
      int lk;
      lk = fps_pkg::LK_DEFAULT;
      if (w >= fps_pkg::KEY3_FIRST) begin
         lk = fps_pkg::LK_KEY3;
      end else if (w >= fps_pkg::KEY2_FIRST) begin
         lk = fps_pkg::LK_KEY2;
      end else if (w >= fps_pkg::KEY1_FIRST) begin
         lk = fps_pkg::LK_KEY1;
      end else if (w == fps_pkg::PAD_WORD) begin
         if (b >= fps_pkg::CIPHER_LSB) begin
            lk = fps_pkg::LK_CFG;
         end else if (b >= fps_pkg::PAD_LAST &&
                      b < fps_pkg::PAD_LAST + fps_pkg::PAD_W) begin
            lk = fps_pkg::LK_PAD_CS;
         end
      end else if (w == fps_pkg::PAD_WORD + 1) begin
         case (b)
            0, 1, 10: lk = fps_pkg::LK_CFG;
            2, 7, 8, 9: lk = fps_pkg::LK_DOWNLOAD;
            4: lk = fps_pkg::LK_ABSTRACT0;
            5: lk = fps_pkg::LK_ABSTRACT1;
            6: lk = fps_pkg::LK_JTAG;
            default: lk = fps_pkg::LK_DEFAULT;
         endcase
      end
      return lk;
   endfunction : lock_bit

   // Bits of one word that the current lock mask still lets burn
   function automatic logic [31:0] burn_allow(input int w,
                                              input logic [15:0] lk);
      logic [31:0] allow;
      allow = '0;
      for (int b = 0; b < 32; b++) begin
         allow[b] = ~lk[lock_bit(w, b)];
      end
      return allow;
   endfunction : burn_allow

   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready_ff & pwrite;

   // Keyed command starts only from idle
   assign start_burn = wr_en && paddr == fps_pkg::CMD_OFF &&
                       pwdata[1:0] == fps_pkg::CMD_BURN &&
                       fuse_op_key_ff == fps_pkg::KEY_BURN &&
                       state_ff == fps_pkg::FPS_IDLE;
   assign start_read = wr_en && paddr == fps_pkg::CMD_OFF &&
                       pwdata[1:0] == fps_pkg::CMD_READ &&
                       fuse_op_key_ff == fps_pkg::KEY_READ &&
                       state_ff == fps_pkg::FPS_IDLE;

   assign done_burn = state_ff == fps_pkg::FPS_BURN && count_ff == 10'd0;
   assign done_read = state_ff == fps_pkg::FPS_READ && count_ff == 10'd0;

   // Program-data words, one bit per fuse bit, key words in order
   for (genvar g = 0; g < NUM_WORDS; g++) begin : g_prog
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            prog_ff[g] <= 32'h0000_0000;
         end else if (wr_en &&
                      word_index(paddr, fps_pkg::PROG_BASE) == g) begin
            prog_ff[g] <= pwdata;
         end
      end

      // Fuse cells: burn sets unlocked marked bits, never clears
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            fuse_ff[g] <= 32'h0000_0000;
         end else if (done_burn) begin
            fuse_ff[g] <= fuse_ff[g] | (prog_ff[g] &
               burn_allow(g, fuse_ff[0][fps_pkg::LOCK_W-1:0]));
         end
      end

      // Parameter copies reload on read-back
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            shadow_ff[g] <= 32'h0000_0000;
         end else if (done_read) begin
            shadow_ff[g] <= fuse_ff[g];
         end
      end
   end

   // Timing selects, set by software for the bus clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timing_ff <= fps_pkg::TIMING_RST;
      end else if (wr_en && paddr == fps_pkg::TIMING_OFF) begin
         timing_ff <= pwdata[15:0];
      end
   end

   // DAC clock divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_dac_cfg_reg_ff <= fps_pkg::DAC_RST;
      end else if (wr_en && paddr == fps_pkg::DAC_OFF) begin
         fuse_dac_cfg_reg_ff <= pwdata[7:0];
      end
   end

   // Operation key; stays stored after a command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_op_key_ff <= fps_pkg::KEY_RST;
      end else if (wr_en && paddr == fps_pkg::KEY_OFF) begin
         fuse_op_key_ff <= pwdata[15:0];
      end
   end

   // Sequencer: burn length from timing selects, read from divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= fps_pkg::FPS_IDLE;
         count_ff <= 10'd0;
      end else begin
         case (state_ff)
            fps_pkg::FPS_IDLE: begin
               if (start_burn) begin
                  state_ff <= fps_pkg::FPS_BURN;
                  count_ff <= 10'(timing_ff.sel_a) + 10'(timing_ff.sel_b);
               end else if (start_read) begin
                  state_ff <= fps_pkg::FPS_READ;
                  count_ff <= 10'(fuse_dac_cfg_reg_ff);
               end
            end
            default: begin
               if (count_ff == 10'd0) begin
                  state_ff <= fps_pkg::FPS_IDLE;
               end else begin
                  count_ff <= count_ff - 10'd1;
               end
            end
         endcase
      end
   end

   // Command register reads back the running operation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_ff <= fps_pkg::CMD_IDLE;
      end else if (start_burn) begin
         cmd_ff <= fps_pkg::CMD_BURN;
      end else if (start_read) begin
         cmd_ff <= fps_pkg::CMD_READ;
      end else if (done_burn || done_read) begin
         cmd_ff <= fps_pkg::CMD_IDLE;
      end
   end

   // Sticky done flags; a new event beats a clear in the same cycle
   always_comb begin
      nxt_raw = raw_ff;
      if (wr_en && paddr == fps_pkg::CLR_OFF) begin
         nxt_raw = raw_ff & ~pwdata[1:0];
      end
      if (done_burn) begin
         nxt_raw[fps_pkg::IRQ_PROG_BIT] = 1'b1;
      end
      if (done_read) begin
         nxt_raw[fps_pkg::IRQ_READ_BIT] = 1'b1;
      end
   end

   assign fuse_irq_status = raw_ff & fuse_irq_enable_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_ff <= 2'b00;
      end else begin
         raw_ff <= nxt_raw;
      end
   end

   // Interrupt enable bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_irq_enable_ff <= 2'b00;
      end else if (wr_en && paddr == fps_pkg::ENA_OFF) begin
         fuse_irq_enable_ff <= pwdata[1:0];
      end
   end

   // Line follows a new enable in the cycle it is written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else if (wr_en && paddr == fps_pkg::ENA_OFF) begin
         irq_ff <= |(nxt_raw & pwdata[1:0]);
      end else begin
         irq_ff <= |(nxt_raw & fuse_irq_enable_ff);
      end
   end

   // Consumer view of block zero word five, pad routing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_ff <= 20'h0_0000;
      end else if (done_read) begin
         pad_ff <= fuse_ff[fps_pkg::PAD_WORD][19:0];
      end
   end

   // Cipher configuration field of the same word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cipher_ff <= 4'h0;
      end else if (done_read) begin
         cipher_ff <= fuse_ff[fps_pkg::PAD_WORD]
                      [fps_pkg::CIPHER_LSB +: fps_pkg::CIPHER_W];
      end
   end

   // Read mux
   always_comb begin
      int pi;
      int ri;
      pi = word_index(paddr, fps_pkg::PROG_BASE);
      ri = word_index(paddr, fps_pkg::READ_BASE);
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      if (pi >= 0) begin
         rd_word = prog_ff[pi];
      end else if (ri >= 0) begin
         rd_word = shadow_ff[ri];
      end else if (paddr == fps_pkg::TIMING_OFF) begin
         rd_word = {16'h0000, timing_ff};
      end else if (paddr == fps_pkg::DAC_OFF) begin
         rd_word = {24'h00_0000, fuse_dac_cfg_reg_ff};
      end else if (paddr == fps_pkg::KEY_OFF) begin
         rd_word = {16'h0000, fuse_op_key_ff};
      end else if (paddr == fps_pkg::CMD_OFF) begin
         rd_word = {30'h0000_0000, cmd_ff};
      end else if (paddr == fps_pkg::RAW_OFF) begin
         rd_word = {30'h0000_0000, raw_ff};
      end else if (paddr == fps_pkg::ST_OFF) begin
         rd_word = {30'h0000_0000, fuse_irq_status};
      end else if (paddr == fps_pkg::ENA_OFF) begin
         rd_word = {30'h0000_0000, fuse_irq_enable_ff};
      end else if (paddr != fps_pkg::CLR_OFF) begin
         rd_hit = 1'b0;
      end
   end

   // APB answer registered in setup, ready in first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
      end
   end

   // Read data captured at setup, zero for writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup) begin
         prdata_ff <= pwrite ? 32'h0000_0000 : rd_word;
      end
   end

   // Error only alongside the ready cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_ff <= 1'b0;
      end else if (setup) begin
         pslverr_ff <= ~rd_hit;
      end else begin
         pslverr_ff <= 1'b0;
      end
   end

   assign prdata                 = prdata_ff;
   assign pready                 = pready_ff;
   assign pslverr                = pslverr_ff;
   assign fuse_irq               = irq_ff;
   assign flash_pad_route_select = pad_ff;
   assign flash_cipher_cfg       = cipher_ff;

endmodule : fps_fuse_program_sequencer
`default_nettype wire

// *** verilog/fps_pkg.sv ***
`default_nettype none
package fps_pkg;
   // Word counts of the program, fuse and read-back arrays
   localparam int BLK0_WORDS = 7;
   localparam int KEY_WORDS  = 8;
   localparam int NUM_KEYS   = 3;
   localparam int NUM_WORDS  = BLK0_WORDS + NUM_KEYS * KEY_WORDS;
   localparam int KEY1_FIRST = BLK0_WORDS;
   localparam int KEY2_FIRST = KEY1_FIRST + KEY_WORDS;
   localparam int KEY3_FIRST = KEY2_FIRST + KEY_WORDS;
   localparam int KEY_BITS   = 256;

   // Byte offsets
   localparam logic [11:0] PROG_BASE  = 12'h0000;
   localparam logic [11:0] READ_BASE  = 12'h0080;
   localparam logic [11:0] TIMING_OFF = 12'h0100;
   localparam logic [11:0] DAC_OFF    = 12'h0104;
   localparam logic [11:0] KEY_OFF    = 12'h0108;
   localparam logic [11:0] CMD_OFF    = 12'h010C;
   localparam logic [11:0] RAW_OFF    = 12'h0110;
   localparam logic [11:0] ST_OFF     = 12'h0114;
   localparam logic [11:0] ENA_OFF    = 12'h0118;
   localparam logic [11:0] CLR_OFF    = 12'h011C;

   // Operation keys and commands
   localparam logic [15:0] KEY_BURN = 16'h5A5A;
   localparam logic [15:0] KEY_READ = 16'h5AA5;
   localparam logic [1:0]  CMD_IDLE = 2'h0;
   localparam logic [1:0]  CMD_READ = 2'h1;
   localparam logic [1:0]  CMD_BURN = 2'h2;

   // Interrupt bit positions
   localparam int IRQ_READ_BIT = 0;
   localparam int IRQ_PROG_BIT = 1;

   // Reset values
   localparam logic [15:0] TIMING_RST = 16'h0000;
   localparam logic [7:0]  DAC_RST    = 8'h00;
   localparam logic [15:0] KEY_RST    = 16'h0000;

   // Word 5 of block zero: pad routing and cipher fields
   localparam int PAD_WORD   = 5;
   localparam int PAD_W      = 5;
   localparam int PAD_LAST   = 15;
   localparam int CIPHER_LSB = 28;
   localparam int CIPHER_W   = 4;

   // Write-lock mask: word 0 bits [15:0]
   localparam int LOCK_W       = 16;
   localparam int LK_DEFAULT   = 0;
   localparam int LK_PAD_CS    = 6;
   localparam int LK_KEY1      = 7;
   localparam int LK_KEY2      = 8;
   localparam int LK_KEY3      = 9;
   localparam int LK_CFG       = 10;
   localparam int LK_ABSTRACT0 = 12;
   localparam int LK_ABSTRACT1 = 13;
   localparam int LK_JTAG      = 14;
   localparam int LK_DOWNLOAD  = 15;

   typedef enum {FPS_IDLE, FPS_BURN, FPS_READ} fps_state_t;

   typedef struct packed {
      logic [7:0] sel_b;
      logic [7:0] sel_a;
   } fps_timing_t;
endpackage : fps_pkg
`default_nettype wire

// *** tb/fps_fuse_program_sequencer_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module fps_fuse_program_sequencer_assertions #(
   parameter int NUM_WORDS = fps_pkg::NUM_WORDS
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        fuse_irq,
   input wire logic [19:0] flash_pad_route_select,
   input wire logic [3:0]  flash_cipher_cfg
);
   logic       acc;
   logic       rd;
   logic [1:0] ena_ff;
   assign acc = psel && penable && pready;
   assign rd  = acc && !pwrite;
   // Shadow of the enable bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ena_ff <= 2'h0;
      end else if (acc && pwrite && paddr == fps_pkg::ENA_OFF) begin
         ena_ff <= pwdata[1:0];
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   a_ready_pulse: assert property (s_setup |=> s_answer)
      else $error("pready is not a one-cycle answer");
   a_err_unmapped: assert property (acc && paddr >= 12'h120 |-> pslverr)
      else $error("unmapped access without error");
   a_ok_prog: assert property (acc && paddr < 12'(4 * NUM_WORDS)
      && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("program word access flagged as error");
   a_err_rd_zero: assert property (rd && pslverr |-> prdata == 32'h0)
      else $error("error read returned data");
   a_cmd_value: assert property (rd && paddr == fps_pkg::CMD_OFF
      |-> prdata[31:2] == 30'h0 && prdata[1:0] != 2'h3)
      else $error("command register holds an illegal value");
   a_raw_bits: assert property (rd && paddr == fps_pkg::RAW_OFF
      |-> prdata[31:2] == 30'h0)
      else $error("raw register has stray bits");
   a_status_ena: assert property (rd && paddr == fps_pkg::ST_OFF
      |-> (prdata & ~{30'h0, ena_ff}) == 32'h0)
      else $error("status shows a disabled event");
   a_irq_ena: assert property (fuse_irq |-> ena_ff != 2'h0)
      else $error("interrupt with no event enabled");
   a_clr_reads: assert property (rd && paddr == fps_pkg::CLR_OFF
      |-> prdata == 32'h0)
      else $error("clear register reads nonzero");
   a_irq_cleared: assert property (acc && pwrite
      && paddr == fps_pkg::CLR_OFF && (pwdata[1:0] | ~ena_ff) == 2'h3
      |=> !fuse_irq)
      else $error("interrupt stays after clear");
   a_fuse_monotone: assert property (
      ($past({flash_cipher_cfg, flash_pad_route_select})
       & ~{flash_cipher_cfg, flash_pad_route_select}) == 24'h00_0000)
      else $error("burned fuse bit seen cleared");
endmodule : fps_fuse_program_sequencer_assertions
bind fps_fuse_program_sequencer fps_fuse_program_sequencer_assertions #(
   .NUM_WORDS(NUM_WORDS)
) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .fuse_irq(fuse_irq),
   .flash_pad_route_select(flash_pad_route_select),
   .flash_cipher_cfg(flash_cipher_cfg));
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        fuse_irq;
   logic [19:0] pad;
   logic [3:0]  cipher;
   logic [31:0] q;
   logic        e;
   int          n_errors;
   int          total_checks;
   int          cycles;

   fps_fuse_program_sequencer u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fuse_irq(fuse_irq), .flash_pad_route_select(pad),
      .flash_cipher_cfg(cipher));

   always #2 pclk = ~pclk;

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 10000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (n_errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk($sformatf("read %h", a), q, x);
   endtask : rdc

   task automatic op(input logic [15:0] k, input logic [1:0] c);
      int n;
      apb(1'b1, fps_pkg::KEY_OFF, {16'h0000, k});
      apb(1'b1, fps_pkg::CMD_OFF, {30'h0, c});
      rdc(fps_pkg::CMD_OFF, {30'h0, c});
      n = 0;
      do begin
         apb(1'b0, fps_pkg::CMD_OFF, 32'h0000_0000);
         n++;
      end while (q !== 32'h0000_0000 && n < 400);
      chk("command done", q, 32'h0000_0000);
   endtask : op

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      n_errors = 0;
      total_checks = 0;
      cycles = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rdc(fps_pkg::TIMING_OFF + 12'(4 * i), 32'h0000_0000);
      end
      rdc(12'h120, 32'h0000_0000);
      chk("unmapped error", {31'h0, e}, 32'h0000_0001);
      apb(1'b1, fps_pkg::RAW_OFF, 32'h0000_0003);
      rdc(fps_pkg::RAW_OFF, 32'h0000_0000);
      apb(1'b1, fps_pkg::KEY_OFF, 32'h0000_5AA5);
      apb(1'b1, fps_pkg::CMD_OFF, 32'h0000_0002);
      rdc(fps_pkg::CMD_OFF, 32'h0000_0000);
      // Timing for a 250 MHz bus clock
      apb(1'b1, fps_pkg::TIMING_OFF, 32'h0000_FFFA);
      apb(1'b1, fps_pkg::DAC_OFF, 32'h0000_0034);
      rdc(fps_pkg::TIMING_OFF, 32'h0000_FFFA);
      apb(1'b1, 12'h014, 32'h5000_8421);
      apb(1'b1, 12'h038, 32'hA5A5_0001);
      rdc(12'h014, 32'h5000_8421);
      apb(1'b1, fps_pkg::ENA_OFF, 32'h0000_0002);
      op(fps_pkg::KEY_BURN, fps_pkg::CMD_BURN);
      chk("irq", {31'h0, fuse_irq}, 32'h0000_0001);
      rdc(fps_pkg::RAW_OFF, 32'h0000_0002);
      rdc(fps_pkg::ST_OFF, 32'h0000_0002);
      rdc(12'h094, 32'h0000_0000);
      op(fps_pkg::KEY_READ, fps_pkg::CMD_READ);
      rdc(fps_pkg::RAW_OFF, 32'h0000_0003);
      rdc(fps_pkg::ST_OFF, 32'h0000_0002);
      rdc(12'h094, 32'h5000_8421);
      rdc(12'h0B8, 32'hA5A5_0001);
      chk("pad", {12'h0, pad}, 32'h0000_8421);
      chk("cipher", {28'h0, cipher}, 32'h0000_0005);
      apb(1'b1, fps_pkg::CLR_OFF, 32'h0000_0002);
      // Line drops at the edge the clear lands; look one edge later
      @(posedge pclk);
      chk("irq", {31'h0, fuse_irq}, 32'h0000_0000);
      rdc(fps_pkg::RAW_OFF, 32'h0000_0001);
      apb(1'b1, fps_pkg::CLR_OFF, 32'h0000_0001);
      rdc(fps_pkg::RAW_OFF, 32'h0000_0000);
      // Lock the pad field together with a new pad bit
      apb(1'b1, 12'h000, 32'h0000_0040);
      apb(1'b1, 12'h014, 32'h0000_0002);
      apb(1'b1, 12'h038, 32'h0000_0000);
      op(fps_pkg::KEY_BURN, fps_pkg::CMD_BURN);
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b1, 12'h014, 32'h0008_0010);
      op(fps_pkg::KEY_BURN, fps_pkg::CMD_BURN);
      op(fps_pkg::KEY_READ, fps_pkg::CMD_READ);
      rdc(12'h094, 32'h5000_8433);
      rdc(12'h080, 32'h0000_0040);
      chk("pad", {12'h0, pad}, 32'h0000_8433);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
